// ==== hdl/dmsm_pkg.sv ====
// Purpose: Shared constants and types for the deadman timer status mirror
// Assumes: 32-bit AXI4-Lite register bus, 16-bit registers in low bits
// Notes:   Offsets are byte addresses of aligned words
package dmsm_pkg;
   localparam logic [7:0] OFF_COUNT_LIMIT_LOW  = 8'h00;
   localparam logic [7:0] OFF_COUNT_LIMIT_HIGH = 8'h04;
   localparam logic [7:0] OFF_WINDOW_LOW       = 8'h08;
   localparam logic [7:0] OFF_WINDOW_HIGH      = 8'h0C;
   localparam logic [7:0] OFF_COUNTER_HOLD     = 8'h10;
   localparam logic [7:0] OFF_LIVE_LOW         = 8'h14;
   localparam logic [7:0] OFF_LIVE_HIGH        = 8'h18;
   localparam logic [15:0] HOLD_RESET          = 16'h0000;
   localparam logic [1:0]  RESP_OKAY           = 2'h0;
   localparam logic [1:0]  RESP_SLVERR         = 2'h2;

   typedef struct packed {
      logic [15:0] count_limit_low;
      logic [15:0] count_limit_high;
      logic [15:0] window_low;
      logic [15:0] window_high;
   } dmsm_cfg_t;

   typedef struct packed {
      logic [31:0] data;
      logic [1:0]  resp;
   } dmsm_rdata_t;
endpackage

// ==== hdl/dmsm_hold.sv ====
// Purpose: Upper counter snapshot register
// Assumes: capture is a one-cycle pulse from a counter register read
// Notes:   Holds its value between reads
`timescale 1ns/100ps
module dmsm_hold (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Capture
   input  wire logic        capture,
   input  wire logic [15:0] live_counter_high,
   // Snapshot
   output logic      [15:0] counter_upper_hold
);
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         counter_upper_hold <= dmsm_pkg::HOLD_RESET;
      end else if (capture) begin
         counter_upper_hold <= live_counter_high;
      end
   end
endmodule

// ==== hdl/dmsm_top.sv ====
// Purpose: Read-back registers of the deadman timer with AXI4-Lite slave
// Assumes: Configuration words and live counter are on the mclk domain
// Notes:
`timescale 1ns/100ps
module dmsm_top (
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                rstn,
   // Configuration words and live counter
   input  wire dmsm_pkg::dmsm_cfg_t cfg,
   input  wire logic [31:0]         live_counter,
   // AXI4-Lite write address
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready
);
   logic                  aw_held_r;
   logic [7:0]            awaddr_r;
   logic                  w_held_r;
   logic                  bvalid_r;
   logic [1:0]            bresp_r;
   logic                  rvalid_r;
   dmsm_pkg::dmsm_rdata_t rd_r;
   dmsm_pkg::dmsm_rdata_t rd_nxt;
   logic [15:0]           hold_q;
   wire                   aw_take;
   wire                   w_take;
   wire                   ar_take;
   wire                   wr_go;
   wire  [7:0]            wr_addr;
   wire                   wr_known;
   wire                   counter_read;

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == dmsm_pkg::OFF_COUNT_LIMIT_LOW) ||
                   (a == dmsm_pkg::OFF_COUNT_LIMIT_HIGH) ||
                   (a == dmsm_pkg::OFF_WINDOW_LOW) ||
                   (a == dmsm_pkg::OFF_WINDOW_HIGH) ||
                   (a == dmsm_pkg::OFF_COUNTER_HOLD) ||
                   (a == dmsm_pkg::OFF_LIVE_LOW) ||
                   (a == dmsm_pkg::OFF_LIVE_HIGH);
   endfunction

   // Write channel handshakes; a write completes once both halves are in
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready  = !w_held_r && !bvalid_r;
   assign aw_take       = s_axi_awvalid && s_axi_awready;
   assign w_take        = s_axi_wvalid && s_axi_wready;
   assign wr_go         = (aw_held_r || aw_take) && (w_held_r || w_take);
   assign wr_addr       = aw_held_r ? awaddr_r : s_axi_awaddr;
   assign wr_known      = addr_known({wr_addr[7:2], 2'b00});
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;

   // Read channel
   assign s_axi_arready = !rvalid_r;
   assign ar_take       = s_axi_arvalid && s_axi_arready;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rd_r.data;
   assign s_axi_rresp   = rd_r.resp;
   // Either counter half being read takes the snapshot
   assign counter_read  = ar_take &&
      ((s_axi_araddr[7:2] == dmsm_pkg::OFF_LIVE_LOW[7:2]) ||
       (s_axi_araddr[7:2] == dmsm_pkg::OFF_LIVE_HIGH[7:2]));

   always_comb begin
      rd_nxt.resp = dmsm_pkg::RESP_OKAY;
      rd_nxt.data = 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'b00})
         dmsm_pkg::OFF_COUNT_LIMIT_LOW: begin
            rd_nxt.data[15:0] = cfg.count_limit_low;
         end
         dmsm_pkg::OFF_COUNT_LIMIT_HIGH: begin
            rd_nxt.data[15:0] = cfg.count_limit_high;
         end
         dmsm_pkg::OFF_WINDOW_LOW: begin
            rd_nxt.data[15:0] = cfg.window_low;
         end
         dmsm_pkg::OFF_WINDOW_HIGH: begin
            rd_nxt.data[15:0] = cfg.window_high;
         end
         dmsm_pkg::OFF_COUNTER_HOLD: begin
            rd_nxt.data[15:0] = hold_q;
         end
         dmsm_pkg::OFF_LIVE_LOW: begin
            rd_nxt.data[15:0] = live_counter[15:0];
         end
         dmsm_pkg::OFF_LIVE_HIGH: begin
            rd_nxt.data[15:0] = live_counter[31:16];
         end
         default: begin
            rd_nxt.resp = dmsm_pkg::RESP_SLVERR;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= 8'h00;
         w_held_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= dmsm_pkg::RESP_OKAY;
      end else if (wr_go) begin
         // Mirrors have no storage: write data is discarded
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         bvalid_r  <= 1'b1;
         bresp_r   <= wr_known ? dmsm_pkg::RESP_OKAY
                               : dmsm_pkg::RESP_SLVERR;
      end else begin
         if (aw_take) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_r <= 1'b1;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rvalid_r <= 1'b0;
         rd_r     <= '0;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rd_r     <= rd_nxt;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   dmsm_hold u_hold (
      .mclk              (mclk),
      .rstn              (rstn),
      .capture           (counter_read),
      .live_counter_high (live_counter[31:16]),
      .counter_upper_hold(hold_q)
   );
endmodule

// ==== tb/dmsm_sva.sv ====
// Purpose: Port checks for dmsm_top
// Assumes: One clock, sync reset
// Notes:   hold_r tracks the upper counter snapshot
`timescale 1ns/100ps
module dmsm_sva (
   // Clock and reset
   input wire logic                mclk,
   input wire logic                rstn,
   // Sources
   input wire dmsm_pkg::dmsm_cfg_t cfg,
   input wire logic [31:0]         live_counter,
   // Bus
   input wire logic [7:0]          s_axi_araddr,
   input wire logic                s_axi_arvalid,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_bvalid
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   wire         ar  = s_axi_arvalid && !s_axi_rvalid;
   wire  [5:0]  ix  = s_axi_araddr[7:2];
   wire         cap = ar && (ix == 6'h05 || ix == 6'h06);
   logic [15:0] hold_r;
   always_ff @(posedge mclk)
      if (!rstn) hold_r <= 16'h0000;
      else if (cap) hold_r <= live_counter[31:16];
   property rd_p(int i, logic [15:0] v);
      ar && ix == i |=> s_axi_rdata == {16'h0000, $past(v)};
   endproperty
   lim_lo_a: assert property (rd_p(0, cfg.count_limit_low))
      else $error("limit low");
   lim_hi_a: assert property (rd_p(1, cfg.count_limit_high))
      else $error("limit high");
   win_lo_a: assert property (rd_p(2, cfg.window_low))
      else $error("window low");
   win_hi_a: assert property (rd_p(3, cfg.window_high))
      else $error("window high");
   hold_read_a: assert property (rd_p(4, hold_r))
      else $error("hold");
   live_lo_a: assert property (rd_p(5, live_counter[15:0]))
      else $error("live low");
   live_hi_a: assert property (rd_p(6, live_counter[31:16]))
      else $error("live high");
   read_answer_a: assert property (ar |=> s_axi_rvalid)
      else $error("no read answer");
   cover property (ar && ix == 6'h04);
   cover property (cap);
   cover property ($rose(s_axi_bvalid));
endmodule
bind dmsm_top dmsm_sva dmsm_sva_inst (.mclk, .rstn, .cfg, .live_counter,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_bvalid);

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for dmsm_top
// Assumes: AXI4-Lite master tasks, live counter always moving
// Notes:   hq models the snapshot register
`timescale 1ns/100ps
module tb_top;
   logic mclk = 1'h0, rstn = 1'h0;
   dmsm_pkg::dmsm_cfg_t cfg;
   logic [31:0] live_counter = '0, lf = 32'hF4F1, wdata = '0, rdata;
   logic [7:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int miscompares = 0, checks = 0, cyc = 0, hq = 0;
   always #2 mclk = ~mclk;
   dmsm_top dmsm_top_inst (.mclk, .rstn, .cfg, .live_counter,
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
      end
   endtask
   task complete_run;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task rst;
      rstn <= 1'h0;
      repeat (12) @(posedge mclk);
      rstn <= 1'h1;
      hq = 0;
   endtask
   task wr(input logic [7:0] a);
      @(posedge mclk);
      awaddr <= a;
      wdata <= lf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do @(posedge mclk); while (!(awready && wready));
      awvalid <= 1'h0;
      wvalid <= 1'h0;
      do @(posedge mclk); while (!bvalid);
      bready <= 1'h0;
      chk(bresp, a < 8'h1C ? 2'h0 : 2'h2);
   endtask
   task rd(input logic [7:0] a);
      logic [31:0] e;
      @(posedge mclk);
      arvalid <= 1'h1;
      araddr <= a;
      rready <= 1'h1;
      do @(posedge mclk); while (!arready);
      e = '0;
      case (a[7:2])
         6'h00: e[15:0] = cfg.count_limit_low;
         6'h01: e[15:0] = cfg.count_limit_high;
         6'h02: e[15:0] = cfg.window_low;
         6'h03: e[15:0] = cfg.window_high;
         6'h04: e[15:0] = hq[15:0];
         6'h05: e[15:0] = live_counter[15:0];
         6'h06: e[15:0] = live_counter[31:16];
         default: e = '0;
      endcase
      if (a[7:2] == 6'h05 || a[7:2] == 6'h06) hq = live_counter[31:16];
      arvalid <= 1'h0;
      do @(posedge mclk); while (!rvalid);
      rready <= 1'h0;
      chk({rresp, rdata}, {a < 8'h1C ? 2'h0 : 2'h2, e});
   endtask
   always @(posedge mclk) begin
      live_counter <= live_counter + 32'h0001_0003;
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      cfg <= {lf, ~lf};
      rst();
      for (int i = 0; i < 8; i++) rd(8'(i * 4));
      $display("reset reads done");
      for (int i = 0; i < 40; i++) begin
         lf = nx(lf);
         cfg <= {lf, nx(lf)};
         wr({3'h0, lf[2:0], 2'h0});
         rd({3'h0, lf[5:3], 2'h0});
      end
      $display("random traffic done");
      rst();
      rd(8'h10);
      $display("second reset done");
      complete_run();
   end
endmodule
